// file: common/sps_pkg.sv
// Constants, types and register map of the settings profile store.
// Assumes one 100 MHz clock and a plain strobe-style register port.
package sps_pkg;

    // Sizes of the profile item list and the defect map
    localparam int ITEMS   = 8;
    localparam int ITEM_W  = 16;
    localparam int DEFECTS = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_CMD          = 8'h00;
    localparam logic [7:0] ADDR_SLOT_SEL     = 8'h04;
    localparam logic [7:0] ADDR_BOOT_SEL     = 8'h08;
    localparam logic [7:0] ADDR_ITEM_PICK    = 8'h0c;
    localparam logic [7:0] ADDR_ITEM_KEPT    = 8'h10;
    localparam logic [7:0] ADDR_STATUS       = 8'h14;
    localparam logic [7:0] ADDR_DEFECT_IDX   = 8'h18;
    localparam logic [7:0] ADDR_DEFECT_ENTRY = 8'h1c;
    localparam logic [7:0] ADDR_DEFECT_LIVE  = 8'h20;
    localparam logic [2:0] ADDR_SET_PAGE     = 3'h2;  // 0x40..0x5c

    // Command register bit positions
    localparam int CMD_STORE    = 0;
    localparam int CMD_RECALL   = 1;
    localparam int CMD_PERSIST  = 2;
    localparam int CMD_REVERT   = 3;
    localparam int CMD_ACTIVATE = 4;

    // Status register bit positions
    localparam int STAT_BUSY      = 0;
    localparam int STAT_CONVERTED = 1;

    // Slot codes; code 3 is not a slot and is refused
    localparam logic [1:0] SLOT_FACTORY = 2'h0;
    localparam logic [1:0] SLOT_A       = 2'h1;
    localparam logic [1:0] SLOT_B       = 2'h2;

    // Reset values
    localparam logic [1:0] RESET_SLOT_SEL   = SLOT_FACTORY;
    localparam logic [1:0] RESET_BOOT       = SLOT_FACTORY;
    localparam logic [2:0] RESET_ITEM_PICK  = 3'h0;
    localparam logic [1:0] RESET_DEFECT_IDX = 2'h0;
    localparam logic [7:0] RESET_NV_VERSION = 8'h00;

    // Cycles one non-volatile write takes to commit
    localparam int NV_OP_CYCLES = 8;

    typedef logic [ITEMS-1:0][ITEM_W-1:0]   sps_vals_t;
    typedef logic [DEFECTS-1:0][ITEM_W-1:0] sps_defect_map_t;

    typedef struct packed {
        logic             valid;    // Slot has been written at least once
        logic [ITEMS-1:0] present;  // Items held in the slot
        sps_vals_t        val;
    } sps_profile_t;

    typedef enum logic [3:0] {
        NV_SLOT    = 4'h1,
        NV_BOOT    = 4'h2,
        NV_DEFECT  = 4'h4,
        NV_VERSION = 4'h8
    } sps_nv_kind_t;

    typedef struct packed {
        sps_nv_kind_t    kind;
        logic            slot;     // 0 = custom slot a, 1 = custom slot b
        sps_profile_t    prof;
        sps_defect_map_t map;
        logic [1:0]      boot;
        logic [7:0]      version;
    } sps_nv_req_t;

    typedef enum logic [5:0] {
        ST_BOOT = 6'h01,
        ST_CONV = 6'h02,
        ST_VER  = 6'h04,
        ST_LOAD = 6'h08,
        ST_IDLE = 6'h10,
        ST_WAIT = 6'h20
    } sps_state_t;

    // Factory default profile and factory calibrated defect map
    localparam sps_vals_t FACTORY_VALS = {
        16'h0008, 16'h0007, 16'h0006, 16'h0005,
        16'h0004, 16'h0003, 16'h0002, 16'h0001};
    localparam sps_defect_map_t FACTORY_DEFECTS = {
        16'h0d04, 16'h0c03, 16'h0b02, 16'h0a01};

endpackage

// file: hw/sps_nv_store.sv
// Non-volatile store: two custom profile slots, boot choice, defect map
// and the firmware version that wrote them.
// Assumes one request at a time; contents survive RST_IN and are only
// formatted by erase_in, which stands for a blank device.
module sps_nv_store (
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  erase_in,
    input  wire logic                  req_in,
    input  wire sps_pkg::sps_nv_req_t  req_data_in,
    output logic                       done_out,
    output sps_pkg::sps_profile_t [1:0] slots_out,
    output logic [1:0]                 boot_out,
    output sps_pkg::sps_defect_map_t   map_out,
    output logic [7:0]                 version_out
);

    logic                 busy;
    logic [3:0]           count;
    sps_pkg::sps_nv_req_t held;
    logic                 commit;

    assign commit = busy && (count == 4'h0);

    // Write timer; contents change only at the end, so a write is atomic
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy     <= 1'b0;
            count    <= 4'h0;
            done_out <= 1'b0;
            held     <= '0;
        end else begin
            done_out <= commit;
            if (req_in && !busy) begin
                busy  <= 1'b1;
                count <= 4'(sps_pkg::NV_OP_CYCLES - 1);
                held  <= req_data_in;
            end else if (commit) begin
                busy <= 1'b0;
            end else if (busy) begin
                count <= count - 4'h1;
            end
        end
    end

    // Storage cells, formatted only by erase
    always_ff @(posedge clk_in) begin
        if (erase_in) begin
            slots_out   <= '0;
            boot_out    <= sps_pkg::RESET_BOOT;
            map_out     <= sps_pkg::FACTORY_DEFECTS;
            version_out <= sps_pkg::RESET_NV_VERSION;
        end else if (commit) begin
            case (held.kind)
                sps_pkg::NV_SLOT:    slots_out[held.slot] <= held.prof;
                sps_pkg::NV_BOOT:    boot_out <= held.boot;
                sps_pkg::NV_DEFECT:  map_out <= held.map;
                sps_pkg::NV_VERSION: version_out <= held.version;
                default:             ;
            endcase
        end
    end

endmodule // sps_nv_store

// file: hw/sps_profile_store.sv
// Settings profile store: live settings, profile slots, boot recall,
// conversion after a firmware change and defect map persistence.
// Assumes a single-cycle strobe register port with read data one cycle
// later, and firmware version and item list inputs that stay steady.
//
// Decided for this implementation: the address map and the address-and-strobe port.

// How it works
// - Persist command writes the edited defect map to storage, replacing it.
// - Every start-up loads the stored defect map as the active map.
// - Factory revert puts the calibration map everywhere, edits discarded.
// - Activate copies edited map into the active map only, not storage.
// - Slot selector picks factory, slot a or slot b for store and recall.
// - The factory profile is always available and can never be overwritten.
// - Store captures all kept live settings into the selected slot.
// - Recall loads the selected slot into the live settings.
// - Recall of a never written slot applies factory settings.
// - Every start-up recalls the slot named by the boot choice.
// - Boot choice starts at factory and keeps written slots across restarts.
// - Fixed item list; item pick register and read-only kept flag.
// - Non-profile settings such as the defect map ignore store and recall.
// - First start after a firmware change converts every saved slot.
// - Conversion drops unsupported items from all saved slots.
// - Conversion fills missing items from the factory default profile.
module sps_profile_store (
    input  wire logic                CLK_IN,
    input  wire logic                RST_IN,
    input  wire logic                NV_ERASE_IN,
    input  wire logic [7:0]          FW_VERSION_IN,
    input  wire logic [7:0]          FW_ITEM_MASK_IN,
    input  wire logic [7:0]          ADDR_IN,
    input  wire logic [31:0]         WDATA_IN,
    input  wire logic                WR_IN,
    input  wire logic                RD_IN,
    output logic [31:0]              RDATA_OUT,
    output logic                     BUSY_OUT,
    output sps_pkg::sps_vals_t       SETTINGS_OUT,
    output sps_pkg::sps_defect_map_t DEFECT_MAP_OUT
);

    sps_pkg::sps_state_t          state;
    sps_pkg::sps_state_t          next_state;
    sps_pkg::sps_state_t          ret_state;
    logic                         conv_slot;
    logic                         converted;
    logic [1:0]                   slot_sel;
    logic [2:0]                   item_pick;
    logic [1:0]                   defect_idx;
    sps_pkg::sps_defect_map_t     edit_map;
    sps_pkg::sps_nv_req_t         nv_req;
    logic                         nv_go;
    logic                         nv_done;
    sps_pkg::sps_profile_t [1:0]  nv_slots;
    logic [1:0]                   nv_boot;
    sps_pkg::sps_defect_map_t     nv_map;
    logic [7:0]                   nv_version;
    logic                         idle;
    logic                         cmd_wr;
    logic                         take_store;
    logic                         take_recall;
    logic                         take_persist;
    logic                         take_revert;
    logic                         take_activate;
    logic                         take_boot;
    logic                         set_hit;
    logic [31:0]                  rd_value;

    // Converts a saved slot to the item list of the running firmware
    function automatic sps_pkg::sps_profile_t convert(
        input sps_pkg::sps_profile_t p,
        input logic [7:0]            mask);
        sps_pkg::sps_profile_t r;
        r = p;
        for (int i = 0; i < sps_pkg::ITEMS; i++) begin
            if (!mask[i]) begin
                r.val[i] = '0;
            end else if (!p.present[i]) begin
                r.val[i] = sps_pkg::FACTORY_VALS[i];
            end
        end
        r.present = mask;
        return r;
    endfunction

    // Effective contents of a slot as recall sees it
    function automatic sps_pkg::sps_profile_t slot_view(
        input logic [1:0]                  sel,
        input sps_pkg::sps_profile_t [1:0] s,
        input logic [7:0]                  mask);
        sps_pkg::sps_profile_t r;
        r = '{valid: 1'b1, present: mask, val: sps_pkg::FACTORY_VALS};
        if (sel == sps_pkg::SLOT_A && s[0].valid) begin
            r = s[0];
        end else if (sel == sps_pkg::SLOT_B && s[1].valid) begin
            r = s[1];
        end
        return r;
    endfunction

    // Overlays kept items of a profile on the live settings
    function automatic sps_pkg::sps_vals_t apply(
        input sps_pkg::sps_vals_t    cur,
        input sps_pkg::sps_profile_t p,
        input logic [7:0]            mask);
        sps_pkg::sps_vals_t r;
        r = cur;
        for (int i = 0; i < sps_pkg::ITEMS; i++) begin
            if (mask[i] && p.present[i]) begin
                r[i] = p.val[i];
            end
        end
        return r;
    endfunction

    sps_nv_store u_nv (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .erase_in    (NV_ERASE_IN),
        .req_in      (nv_go),
        .req_data_in (nv_req),
        .done_out    (nv_done),
        .slots_out   (nv_slots),
        .boot_out    (nv_boot),
        .map_out     (nv_map),
        .version_out (nv_version)
    );

    // Command decode; one command per write, store highest priority
    assign idle          = (state == sps_pkg::ST_IDLE);
    assign cmd_wr        = WR_IN && idle && (ADDR_IN == sps_pkg::ADDR_CMD);
    assign take_store    = cmd_wr && WDATA_IN[sps_pkg::CMD_STORE]
                           && (slot_sel != sps_pkg::SLOT_FACTORY);
    assign take_recall   = cmd_wr && !WDATA_IN[sps_pkg::CMD_STORE]
                           && WDATA_IN[sps_pkg::CMD_RECALL];
    assign take_persist  = cmd_wr && (WDATA_IN[1:0] == 2'h0)
                           && WDATA_IN[sps_pkg::CMD_PERSIST];
    assign take_revert   = cmd_wr && (WDATA_IN[2:0] == 3'h0)
                           && WDATA_IN[sps_pkg::CMD_REVERT];
    assign take_activate = cmd_wr && (WDATA_IN[3:0] == 4'h0)
                           && WDATA_IN[sps_pkg::CMD_ACTIVATE];
    assign take_boot     = WR_IN && idle
                           && (ADDR_IN == sps_pkg::ADDR_BOOT_SEL)
                           && (WDATA_IN[1:0] != 2'h3);
    assign set_hit       = (ADDR_IN[7:5] == sps_pkg::ADDR_SET_PAGE)
                           && (ADDR_IN[1:0] == 2'h0);

    // Sequencer: boot check, conversion, boot recall, then commands
    always_comb begin
        next_state = state;
        case (state)
            sps_pkg::ST_BOOT: begin
                if (nv_version != FW_VERSION_IN) begin
                    next_state = sps_pkg::ST_CONV;
                end else begin
                    next_state = sps_pkg::ST_LOAD;
                end
            end
            sps_pkg::ST_CONV: next_state = sps_pkg::ST_WAIT;
            sps_pkg::ST_VER:  next_state = sps_pkg::ST_WAIT;
            sps_pkg::ST_LOAD: next_state = sps_pkg::ST_IDLE;
            sps_pkg::ST_IDLE: begin
                if (take_store || take_persist || take_revert
                    || take_boot) begin
                    next_state = sps_pkg::ST_WAIT;
                end
            end
            sps_pkg::ST_WAIT: begin
                if (nv_done) begin
                    next_state = ret_state;
                end
            end
            default: next_state = sps_pkg::ST_BOOT;
        endcase
    end

    // State, return point and conversion progress
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state     <= sps_pkg::ST_BOOT;
            ret_state <= sps_pkg::ST_IDLE;
            conv_slot <= 1'b0;
            converted <= 1'b0;
            BUSY_OUT  <= 1'b1;
        end else begin
            state    <= next_state;
            BUSY_OUT <= (next_state != sps_pkg::ST_IDLE);
            if (state == sps_pkg::ST_CONV) begin
                conv_slot <= 1'b1;
                ret_state <= conv_slot ? sps_pkg::ST_VER
                                       : sps_pkg::ST_CONV;
            end else if (state == sps_pkg::ST_VER) begin
                converted <= 1'b1;
                ret_state <= sps_pkg::ST_LOAD;
            end else if (idle) begin
                ret_state <= sps_pkg::ST_IDLE;
            end
        end
    end

    // Storage requests; the store only writes once the sequencer waits
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            nv_go  <= 1'b0;
            nv_req <= '0;
        end else begin
            nv_go <= 1'b0;
            if (state == sps_pkg::ST_CONV) begin
                nv_go       <= 1'b1;
                nv_req.kind <= sps_pkg::NV_SLOT;
                nv_req.slot <= conv_slot;
                nv_req.prof <= convert(nv_slots[conv_slot],
                                       FW_ITEM_MASK_IN);
            end else if (state == sps_pkg::ST_VER) begin
                nv_go          <= 1'b1;
                nv_req.kind    <= sps_pkg::NV_VERSION;
                nv_req.version <= FW_VERSION_IN;
            end else if (take_store) begin
                nv_go       <= 1'b1;
                nv_req.kind <= sps_pkg::NV_SLOT;
                nv_req.slot <= (slot_sel == sps_pkg::SLOT_B);
                nv_req.prof <= convert('{valid: 1'b1,
                                         present: FW_ITEM_MASK_IN,
                                         val: SETTINGS_OUT},
                                       FW_ITEM_MASK_IN);
            end else if (take_persist || take_revert) begin
                nv_go       <= 1'b1;
                nv_req.kind <= sps_pkg::NV_DEFECT;
                nv_req.map  <= take_revert ? sps_pkg::FACTORY_DEFECTS
                                           : edit_map;
            end else if (take_boot) begin
                nv_go       <= 1'b1;
                nv_req.kind <= sps_pkg::NV_BOOT;
                nv_req.boot <= WDATA_IN[1:0];
            end
        end
    end

    // Live settings: boot recall, recall command and direct writes
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            SETTINGS_OUT <= sps_pkg::FACTORY_VALS;
        end else if (state == sps_pkg::ST_LOAD || take_recall) begin
            SETTINGS_OUT <= apply(SETTINGS_OUT,
                                  slot_view(idle ? slot_sel : nv_boot,
                                            nv_slots, FW_ITEM_MASK_IN),
                                  FW_ITEM_MASK_IN);
        end else if (WR_IN && idle && set_hit) begin
            SETTINGS_OUT[ADDR_IN[4:2]] <= WDATA_IN[15:0];
        end
    end

    // Defect maps: edited copy and active copy, neither in profiles
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            edit_map       <= sps_pkg::FACTORY_DEFECTS;
            DEFECT_MAP_OUT <= sps_pkg::FACTORY_DEFECTS;
        end else if (state == sps_pkg::ST_LOAD) begin
            edit_map       <= nv_map;
            DEFECT_MAP_OUT <= nv_map;
        end else if (take_revert) begin
            edit_map       <= sps_pkg::FACTORY_DEFECTS;
            DEFECT_MAP_OUT <= sps_pkg::FACTORY_DEFECTS;
        end else if (take_activate) begin
            DEFECT_MAP_OUT <= edit_map;
        end else if (WR_IN && idle
                     && ADDR_IN == sps_pkg::ADDR_DEFECT_ENTRY) begin
            edit_map[defect_idx] <= WDATA_IN[15:0];
        end
    end

    // Selectors; a slot code of 3 is refused and the old value stays
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            slot_sel   <= sps_pkg::RESET_SLOT_SEL;
            item_pick  <= sps_pkg::RESET_ITEM_PICK;
            defect_idx <= sps_pkg::RESET_DEFECT_IDX;
        end else if (WR_IN) begin
            if (ADDR_IN == sps_pkg::ADDR_SLOT_SEL) begin
                if (WDATA_IN[1:0] != 2'h3) begin
                    slot_sel <= WDATA_IN[1:0];
                end
            end else if (ADDR_IN == sps_pkg::ADDR_ITEM_PICK) begin
                item_pick <= WDATA_IN[2:0];
            end else if (ADDR_IN == sps_pkg::ADDR_DEFECT_IDX) begin
                defect_idx <= WDATA_IN[1:0];
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (ADDR_IN == sps_pkg::ADDR_SLOT_SEL) begin
            rd_value = {30'h0, slot_sel};
        end else if (ADDR_IN == sps_pkg::ADDR_BOOT_SEL) begin
            rd_value = {30'h0, nv_boot};
        end else if (ADDR_IN == sps_pkg::ADDR_ITEM_PICK) begin
            rd_value = {29'h0, item_pick};
        end else if (ADDR_IN == sps_pkg::ADDR_ITEM_KEPT) begin
            rd_value = {31'h0, FW_ITEM_MASK_IN[item_pick]};
        end else if (ADDR_IN == sps_pkg::ADDR_STATUS) begin
            rd_value[sps_pkg::STAT_BUSY]      = BUSY_OUT;
            rd_value[sps_pkg::STAT_CONVERTED] = converted;
        end else if (ADDR_IN == sps_pkg::ADDR_DEFECT_IDX) begin
            rd_value = {30'h0, defect_idx};
        end else if (ADDR_IN == sps_pkg::ADDR_DEFECT_ENTRY) begin
            rd_value = {16'h0, edit_map[defect_idx]};
        end else if (ADDR_IN == sps_pkg::ADDR_DEFECT_LIVE) begin
            rd_value = {16'h0, DEFECT_MAP_OUT[defect_idx]};
        end else if (set_hit) begin
            rd_value = {16'h0, SETTINGS_OUT[ADDR_IN[4:2]]};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 32'h0000_0000;
        end else begin
            RDATA_OUT <= RD_IN ? rd_value : 32'h0000_0000;
        end
    end

endmodule // sps_profile_store

// file: tb/sps_profile_store_asserts.sv
// Port-level checker of the settings profile store.
// Assumes it is bound to the top module and sees its ports only.
module sps_profile_store_asserts (
    input  wire logic                     CLK_IN,
    input  wire logic                     RST_IN,
    input  wire logic [7:0]               ADDR_IN,
    input  wire logic [31:0]              WDATA_IN,
    input  wire logic                     WR_IN,
    input  wire logic                     RD_IN,
    input  wire logic [31:0]              RDATA_OUT,
    input  wire logic                     BUSY_OUT,
    input  wire sps_pkg::sps_vals_t       SETTINGS_OUT,
    input  wire sps_pkg::sps_defect_map_t DEFECT_MAP_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  wr_item;
    logic [15:0] wr_val;
    wire logic   cmd_ok = WR_IN && ADDR_IN == sps_pkg::ADDR_CMD && !BUSY_OUT;

    // Address and data of the previous cycle, for checks one cycle later
    always_ff @(posedge CLK_IN) begin
        wr_item <= ADDR_IN[4:2];
        wr_val  <= WDATA_IN[15:0];
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    chk_read_idle: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
        else $error("read data not zero");
    chk_reset_state: assert property ($fell(RST_IN) |-> BUSY_OUT &&
        SETTINGS_OUT == sps_pkg::FACTORY_VALS &&
        DEFECT_MAP_OUT == sps_pkg::FACTORY_DEFECTS)
        else $error("reset state wrong");
    chk_persist_busy: assert property (cmd_ok && WDATA_IN[4:0] == 5'h04
        |=> BUSY_OUT)
        else $error("persist not busy");
    chk_busy_holds: assert property ($rose(BUSY_OUT) |-> BUSY_OUT[*8])
        else $error("busy too short");
    chk_busy_ends: assert property ($rose(BUSY_OUT)
        |-> ##[1:20] !BUSY_OUT)
        else $error("busy never ended");
    chk_recall_quick: assert property (cmd_ok && WDATA_IN[4:0] == 5'h02
        |=> !BUSY_OUT)
        else $error("recall raised busy");
    chk_activate_quick: assert property (cmd_ok && WDATA_IN[4:0] == 5'h10
        |=> !BUSY_OUT)
        else $error("activate raised busy");
    chk_revert_map: assert property (cmd_ok && WDATA_IN[4:0] == 5'h08
        |=> DEFECT_MAP_OUT == sps_pkg::FACTORY_DEFECTS && BUSY_OUT)
        else $error("revert map wrong");
    chk_setting_write: assert property (WR_IN && !BUSY_OUT &&
        ADDR_IN[7:5] == sps_pkg::ADDR_SET_PAGE && ADDR_IN[1:0] == 2'h0
        |=> SETTINGS_OUT[wr_item] == wr_val)
        else $error("setting write lost");

    cover property (cmd_ok && WDATA_IN[0]);
    cover property ($fell(BUSY_OUT));
    cover property (RD_IN && ADDR_IN == sps_pkg::ADDR_ITEM_KEPT);
endmodule // sps_profile_store_asserts

bind sps_profile_store sps_profile_store_asserts i_chk (.CLK_IN, .RST_IN,
    .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .BUSY_OUT,
    .SETTINGS_OUT, .DEFECT_MAP_OUT);

// file: tb/sps_profile_store_test.sv
// Self-checking bench of the settings profile store.
// Assumes the checker is bound in and one 100 MHz clock.
module sps_profile_store_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk, rst, erase, wr, rd, busy;
    logic [7:0]               fw_ver, fw_mask, addr;
    logic [31:0]              wdata, rdata;
    sps_pkg::sps_vals_t       settings, ev;
    sps_pkg::sps_defect_map_t map, em;
    int                       fail_count, checked;

    sps_profile_store i_dut (.CLK_IN(clk), .RST_IN(rst), .NV_ERASE_IN(erase),
        .FW_VERSION_IN(fw_ver), .FW_ITEM_MASK_IN(fw_mask), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .BUSY_OUT(busy), .SETTINGS_OUT(settings), .DEFECT_MAP_OUT(map));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [127:0] e,
                         input logic [127:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(what, 128'(e), 128'(rdata));
    endtask
    // Bounded wait, so a stuck busy is reported instead of hanging
    task automatic wait_idle();
        int n = 0;
        @(posedge clk);
        #1;
        while (busy === 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("busy", 128'h0, 128'(busy));
    endtask
    task automatic restart(input logic wipe);
        @(posedge clk);
        rst   <= 1'b1;
        erase <= wipe;
        repeat (8) @(posedge clk);
        rst   <= 1'b0;
        erase <= 1'b0;
        wait_idle();
    endtask
    task automatic cmd(input logic [31:0] c);
        wr_reg(sps_pkg::ADDR_CMD, c);
        wait_idle();
    endtask

    task automatic t_basics();
        check("settings", sps_pkg::FACTORY_VALS, settings);
        check("map", 128'(sps_pkg::FACTORY_DEFECTS), 128'(map));
        rd_reg(sps_pkg::ADDR_BOOT_SEL, 32'h0, "boot choice");
        rd_reg(sps_pkg::ADDR_STATUS, 32'h2, "status");
        wr_reg(sps_pkg::ADDR_ITEM_PICK, 32'h7);
        rd_reg(sps_pkg::ADDR_ITEM_KEPT, 32'h0, "kept flag 7");
        wr_reg(sps_pkg::ADDR_ITEM_PICK, 32'h0);
        rd_reg(sps_pkg::ADDR_ITEM_KEPT, 32'h1, "kept flag 0");
        $display("test basics done");
    endtask

    task automatic t_profiles();
        for (int i = 0; i < 8; i++) begin
            ev[i] = 16'h0100 + 16'(i);
            wr_reg(8'(8'h40 + 4 * i), 32'(ev[i]));
        end
        wr_reg(sps_pkg::ADDR_SLOT_SEL, 32'(sps_pkg::SLOT_A));
        wr_reg(sps_pkg::ADDR_CMD, 32'h1);
        wr_reg(8'h40, 32'h0000dead); // Refused while busy
        wait_idle();
        check("after store", ev, settings);
        wr_reg(8'h44, 32'h0);
        wr_reg(8'h5c, 32'h0055); // Item 7 is not kept
        ev[7] = 16'h0055;
        cmd(32'h2);
        check("recall a", ev, settings);
        ev = sps_pkg::FACTORY_VALS;
        ev[7] = 16'h0055;
        wr_reg(sps_pkg::ADDR_SLOT_SEL, 32'(sps_pkg::SLOT_B));
        cmd(32'h2);
        check("recall blank b", ev, settings);
        wr_reg(8'h48, 32'h0077);
        wr_reg(sps_pkg::ADDR_SLOT_SEL, 32'(sps_pkg::SLOT_FACTORY));
        wr_reg(sps_pkg::ADDR_SLOT_SEL, 32'h3);
        cmd(32'h1);
        cmd(32'h2);
        check("recall factory", ev, settings);
        check("map", 128'(sps_pkg::FACTORY_DEFECTS), 128'(map));
        $display("test profiles done");
    endtask

    task automatic t_defects();
        em = sps_pkg::FACTORY_DEFECTS;
        em[1] = 16'h1234;
        wr_reg(sps_pkg::ADDR_DEFECT_IDX, 32'h1);
        wr_reg(sps_pkg::ADDR_DEFECT_ENTRY, 32'h1234);
        cmd(32'h10);
        check("activated map", 128'(em), 128'(map));
        rd_reg(sps_pkg::ADDR_DEFECT_LIVE, 32'h1234, "live entry");
        restart(1'b0);
        check("map lost", 128'(sps_pkg::FACTORY_DEFECTS), 128'(map));
        wr_reg(sps_pkg::ADDR_DEFECT_IDX, 32'h1);
        wr_reg(sps_pkg::ADDR_DEFECT_ENTRY, 32'h1234);
        cmd(32'h4);
        restart(1'b0);
        check("map persisted", 128'(em), 128'(map));
        cmd(32'h8);
        restart(1'b0);
        check("map reverted", 128'(sps_pkg::FACTORY_DEFECTS), 128'(map));
        $display("test defects done");
    endtask

    task automatic t_boot_convert();
        wr_reg(sps_pkg::ADDR_BOOT_SEL, 32'(sps_pkg::SLOT_A));
        wait_idle();
        rd_reg(sps_pkg::ADDR_BOOT_SEL, 32'h1, "boot choice");
        restart(1'b0);
        for (int i = 0; i < 8; i++) ev[i] = 16'h0100 + 16'(i);
        ev[7] = 16'h0008;
        check("boot slot a", ev, settings);
        rd_reg(sps_pkg::ADDR_STATUS, 32'h0, "status");
        @(posedge clk);
        fw_ver  <= 8'h02;
        fw_mask <= 8'hfe;
        restart(1'b0);
        ev[0] = 16'h0001; // Dropped item stays factory
        check("converted boot", ev, settings);
        rd_reg(sps_pkg::ADDR_STATUS, 32'h2, "status");
        wr_reg(8'h5c, 32'h0099);
        wr_reg(sps_pkg::ADDR_SLOT_SEL, 32'(sps_pkg::SLOT_A));
        cmd(32'h2);
        check("filled item", ev, settings);
        $display("test boot_convert done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reaching this span means a hang
    initial begin
        #100us;
        fail_count++;
        $display("unexpected timeout: expected end seen none");
        final_report();
    end

    // Main sequence, starting on a blank storage device
    initial begin
        {rst, erase, wr, rd, addr, wdata} = {1'b1, 1'b1, 42'h0};
        {fw_ver, fw_mask} = {8'h01, 8'h7f};
        {fail_count, checked} = '0;
        restart(1'b1);
        t_basics();
        t_profiles();
        t_defects();
        t_boot_convert();
        final_report();
    end
endmodule // sps_profile_store_test
